/* File: spmp_regs.svh */
// Bit positions, reset values and timing figures of the serial port
`ifndef SPMP_REGS_SVH
`define SPMP_REGS_SVH

// ==========================================================
// Control byte fields
`define SPMP_CTL_DONE 7
`define SPMP_CTL_MST 6
`define SPMP_CTL_FAULT 5
`define SPMP_CTL_SELHI 3
`define SPMP_CTL_SELLO 2
`define SPMP_CTL_TXFULL 1
`define SPMP_CTL_EN 0
`define SPMP_CTL_RESET 8'h04

// ==========================================================
// Configuration byte fields
`define SPMP_CFG_PHASE 5
`define SPMP_CFG_POL 4

// ==========================================================
// Transfer shape
`define SPMP_LAST_EDGE 4'hF
`define SPMP_TAIL_CYC 2'h3

// ==========================================================
// Timing
`define SPMP_LINK_PERIOD_NS 48
`define SPMP_MAX_BIT_KHZ 12500
`define SPMP_MIN_BIT_PERIOD_NS (1000000 / `SPMP_MAX_BIT_KHZ)
`define SPMP_MIN_HALF_CYC ((`SPMP_MIN_BIT_PERIOD_NS / 2 + \
   `SPMP_LINK_PERIOD_NS - 1) / `SPMP_LINK_PERIOD_NS)
`define SPMP_MIN_HALF_DIV (8'(`SPMP_MIN_HALF_CYC - 1))

`endif

/* File: spmp_pkg.sv */
// Types shared by the serial port modules
package spmp_pkg;
   typedef enum logic [1:0] {
      SPMP_IDLE,
      SPMP_RUN,
      SPMP_TAIL
   } spmp_state_e;
   typedef logic [7:0] spmp_byte_t;
endpackage : spmp_pkg

/* File: spmp_edge_if.sv */
// Link-side edge timing between the port core and its clock generator
`timescale 1ns/10ps
interface spmp_edge_if;
   logic run;
   logic [7:0] half_div;
   logic edge_stb;
   logic [3:0] edge_idx;
   modport gen (input run, input half_div, output edge_stb,
      output edge_idx);
   modport user (output run, output half_div, input edge_stb,
      input edge_idx);
endinterface : spmp_edge_if

/* File: spmp_sync.sv */
// Two-flop level synchroniser, one chain per bit
`timescale 1ns/10ps
module spmp_sync #(
   parameter int WIDTH = 1,
   parameter logic [WIDTH-1:0] INIT = '0
) (
   input wire logic i_clk,
   input wire logic i_arst_n,
   input wire logic [WIDTH-1:0] i_d,
   output logic [WIDTH-1:0] o_q
);
   logic [WIDTH-1:0] meta;

   for (genvar b = 0; b < WIDTH; b++) begin : g_bit
      always_ff @(posedge i_clk or negedge i_arst_n) begin
         if (!i_arst_n) begin
            meta[b] <= INIT[b];
            o_q[b] <= INIT[b];
         end else begin
            meta[b] <= i_d[b];
            o_q[b] <= meta[b];
         end
      end
   end
endmodule : spmp_sync

/* File: spmp_clkgen.sv */
// Serial clock divider: half-period strobes and edge numbering
`timescale 1ns/10ps
module spmp_clkgen
   import spmp_pkg::*;
(
   input wire logic i_clk,
   input wire logic i_arst_n,
   spmp_edge_if.gen e
);
`include "spmp_regs.svh"

   logic [7:0] cnt;
   logic [7:0] eff_div;
   logic [3:0] idx;

   // Floor on the half period keeps the bit rate legal
   assign eff_div = (e.half_div < `SPMP_MIN_HALF_DIV) ?
      `SPMP_MIN_HALF_DIV : e.half_div;
   assign e.edge_stb = e.run && (cnt == eff_div);
   assign e.edge_idx = idx;

   always_ff @(posedge i_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         cnt <= 8'h00;
      end else if (!e.run || e.edge_stb) begin
         cnt <= 8'h00;
      end else begin
         cnt <= cnt + 8'h01;
      end
   end

   always_ff @(posedge i_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         idx <= 4'h0;
      end else if (!e.run) begin
         idx <= 4'h0;
      end else if (e.edge_stb) begin
         idx <= idx + 4'h1;
      end
   end
endmodule : spmp_clkgen

/* File: spmp_port.sv */
// Serial peripheral port, master side, with its control state
// What this block does
// - Setting the master and enable bits together puts the port in master operation.
// - Data write fills transmit buffer; idle shifter takes it and starts.
// - Started transfer shifts byte out on MOSI while driving SCK.
// - Done flag sets at transfer end; requests interrupt when enabled.
// - Slave returns its byte on MISO meanwhile; one flag marks both.
// - Received bits enter MSB first; full byte goes to receive buffer.
// - Select mode bits 0 and 1 mean multi-master; select pin is input.
// - Select low in multi-master with enable set clears master and enable, sets fault.
// - Fault requests interrupt; hardware never re-enables, software must.
// - Both select mode bits 0 means 3-wire; select pin unused.
// - Select mode high bit 1 drives select pin with low mode bit.
// - Config bit 5 picks latch edge, bit 4 picks clock polarity.
// - Master and slave must share clock phase and polarity.
// - Clock-rate value sets master SCK rate; ignored as slave.
// - Master bit rate at most half system clock and 12.5 MHz.
`timescale 1ns/10ps
module spmp_port
   import spmp_pkg::*;
(
   input wire logic I_CORE_CLK,
   input wire logic I_ARST_N,
   input wire logic I_LINK_CLK,
   input wire logic I_CTRL_WE,
   input wire logic [7:0] I_CTRL_WDATA,
   output logic [7:0] O_CTRL,
   input wire logic [7:0] I_CONFIG,
   input wire logic [7:0] I_CLK_RATE,
   input wire logic I_DATA_WE,
   input wire logic [7:0] I_DATA_WDATA,
   output logic [7:0] O_DATA,
   output logic O_BUSY,
   input wire logic I_IRQ_EN,
   output logic O_IRQ,
   output logic O_SCK,
   output logic O_SCK_OE,
   output logic O_MOSI,
   output logic O_MOSI_OE,
   input wire logic I_MISO,
   input wire logic I_SS,
   output logic O_SS,
   output logic O_SS_OE
);
`include "spmp_regs.svh"

   // Reset byte as a named constant so its fields can be selected
   localparam spmp_byte_t ctl_init = `SPMP_CTL_RESET;

   // ==========================================================
   // Core-domain control state
   logic master_enable_flag;
   logic port_enable_bit;
   logic transfer_done_flag;
   logic mode_fault_flag;
   logic select_mode_hi;
   logic select_mode_lo;
   spmp_byte_t tx_buf;
   logic tx_full;
   logic busy;
   spmp_byte_t rx_buf;
   spmp_byte_t tx_hold;
   logic phase_hold;
   spmp_byte_t rate_hold;
   logic start_tgl;
   logic done_prev;
   logic ss_s;
   logic done_s;
   logic done_evt;
   logic fault_set;
   logic load;
   logic multi_mode;

   // ==========================================================
   // Link-domain state
   spmp_state_e state;
   spmp_byte_t tx_sh;
   spmp_byte_t rx_sh;
   spmp_byte_t rx_out;
   logic sck;
   logic phase_l;
   logic done_tgl;
   logic start_prev;
   logic [1:0] samp_pipe;
   logic [1:0] tail_cnt;
   logic start_s;
   logic pol_s;
   logic miso_s;
   logic start_evt;
   logic sample_now;
   logic shift_now;

   spmp_edge_if edge_bus ();

   // ==========================================================
   // Crossings into the core domain
   // Select idles high so a reset release does not look like a fault
   spmp_sync #(
      .WIDTH(1),
      .INIT(1'b1)
   ) u_ss_sync (
      .i_clk(I_CORE_CLK),
      .i_arst_n(I_ARST_N),
      .i_d(I_SS),
      .o_q(ss_s)
   );

   spmp_sync #(
      .WIDTH(1),
      .INIT(1'b0)
   ) u_done_sync (
      .i_clk(I_CORE_CLK),
      .i_arst_n(I_ARST_N),
      .i_d(done_tgl),
      .o_q(done_s)
   );

   // ==========================================================
   // Crossings into the link domain
   spmp_sync #(
      .WIDTH(3),
      .INIT(3'b000)
   ) u_link_sync (
      .i_clk(I_LINK_CLK),
      .i_arst_n(I_ARST_N),
      .i_d({start_tgl, I_CONFIG[`SPMP_CFG_POL], I_MISO}),
      .o_q({start_s, pol_s, miso_s})
   );

   spmp_clkgen u_clkgen (
      .i_clk(I_LINK_CLK),
      .i_arst_n(I_ARST_N),
      .e(edge_bus)
   );

   // ==========================================================
   // Core-domain events
   assign done_evt = done_s ^ done_prev;
   assign multi_mode = !select_mode_hi && select_mode_lo;
   assign fault_set = multi_mode && !ss_s && port_enable_bit;
   assign load = tx_full && !busy && master_enable_flag &&
      port_enable_bit;

   always_ff @(posedge I_CORE_CLK or negedge I_ARST_N) begin
      if (!I_ARST_N) begin
         done_prev <= 1'b0;
      end else begin
         done_prev <= done_s;
      end
   end

   // ==========================================================
   // Control byte
   // A fault wins over a same-cycle software enable; the port stays
   // off until software writes the enables again
   always_ff @(posedge I_CORE_CLK or negedge I_ARST_N) begin
      if (!I_ARST_N) begin
         master_enable_flag <= ctl_init[`SPMP_CTL_MST];
         port_enable_bit <= ctl_init[`SPMP_CTL_EN];
      end else if (fault_set) begin
         master_enable_flag <= 1'b0;
         port_enable_bit <= 1'b0;
      end else if (I_CTRL_WE) begin
         master_enable_flag <= I_CTRL_WDATA[`SPMP_CTL_MST];
         port_enable_bit <= I_CTRL_WDATA[`SPMP_CTL_EN];
      end
   end

   always_ff @(posedge I_CORE_CLK or negedge I_ARST_N) begin
      if (!I_ARST_N) begin
         select_mode_hi <= ctl_init[`SPMP_CTL_SELHI];
         select_mode_lo <= ctl_init[`SPMP_CTL_SELLO];
      end else if (I_CTRL_WE) begin
         select_mode_hi <= I_CTRL_WDATA[`SPMP_CTL_SELHI];
         select_mode_lo <= I_CTRL_WDATA[`SPMP_CTL_SELLO];
      end
   end

   // Hardware set beats a software clear in the same cycle
   always_ff @(posedge I_CORE_CLK or negedge I_ARST_N) begin
      if (!I_ARST_N) begin
         transfer_done_flag <= ctl_init[`SPMP_CTL_DONE];
      end else if (done_evt) begin
         transfer_done_flag <= 1'b1;
      end else if (I_CTRL_WE) begin
         transfer_done_flag <= I_CTRL_WDATA[`SPMP_CTL_DONE];
      end
   end

   always_ff @(posedge I_CORE_CLK or negedge I_ARST_N) begin
      if (!I_ARST_N) begin
         mode_fault_flag <= ctl_init[`SPMP_CTL_FAULT];
      end else if (fault_set) begin
         mode_fault_flag <= 1'b1;
      end else if (I_CTRL_WE) begin
         mode_fault_flag <= I_CTRL_WDATA[`SPMP_CTL_FAULT];
      end
   end

   always_comb begin
      O_CTRL = 8'h00;
      O_CTRL[`SPMP_CTL_DONE] = transfer_done_flag;
      O_CTRL[`SPMP_CTL_MST] = master_enable_flag;
      O_CTRL[`SPMP_CTL_FAULT] = mode_fault_flag;
      O_CTRL[`SPMP_CTL_SELHI] = select_mode_hi;
      O_CTRL[`SPMP_CTL_SELLO] = select_mode_lo;
      O_CTRL[`SPMP_CTL_TXFULL] = tx_full;
      O_CTRL[`SPMP_CTL_EN] = port_enable_bit;
   end

   assign O_IRQ = I_IRQ_EN &&
      (transfer_done_flag || mode_fault_flag);

   // ==========================================================
   // Transmit buffer and transfer launch
   // A write onto a full buffer replaces the waiting byte
   always_ff @(posedge I_CORE_CLK or negedge I_ARST_N) begin
      if (!I_ARST_N) begin
         tx_buf <= 8'h00;
         tx_full <= 1'b0;
      end else if (I_DATA_WE) begin
         tx_buf <= I_DATA_WDATA;
         tx_full <= 1'b1;
      end else if (load) begin
         tx_full <= 1'b0;
      end
   end

   // Held bytes stay still until the link answers, so the link
   // may read them without its own synchroniser
   always_ff @(posedge I_CORE_CLK or negedge I_ARST_N) begin
      if (!I_ARST_N) begin
         tx_hold <= 8'h00;
         phase_hold <= 1'b0;
         rate_hold <= 8'h00;
         start_tgl <= 1'b0;
      end else if (load) begin
         tx_hold <= tx_buf;
         phase_hold <= I_CONFIG[`SPMP_CFG_PHASE];
         rate_hold <= I_CLK_RATE;
         start_tgl <= !start_tgl;
      end
   end

   always_ff @(posedge I_CORE_CLK or negedge I_ARST_N) begin
      if (!I_ARST_N) begin
         busy <= 1'b0;
      end else if (load) begin
         busy <= 1'b1;
      end else if (done_evt) begin
         busy <= 1'b0;
      end
   end

   assign O_BUSY = busy;

   // ==========================================================
   // Receive buffer
   always_ff @(posedge I_CORE_CLK or negedge I_ARST_N) begin
      if (!I_ARST_N) begin
         rx_buf <= 8'h00;
      end else if (done_evt) begin
         rx_buf <= rx_out;
      end
   end

   assign O_DATA = rx_buf;

   // ==========================================================
   // Pins
   assign O_SCK_OE = master_enable_flag && port_enable_bit;
   assign O_MOSI_OE = master_enable_flag && port_enable_bit;
   assign O_SS = select_mode_lo;
   // Three-wire and multi-master leave the select pin undriven
   assign O_SS_OE = select_mode_hi;
   assign O_SCK = sck;
   assign O_MOSI = tx_sh[7];

   // ==========================================================
   // Link-domain transfer engine
   assign start_evt = start_s ^ start_prev;
   assign edge_bus.run = (state == SPMP_RUN);
   assign edge_bus.half_div = rate_hold;
   // Even edges lead, odd edges trail
   assign sample_now = (edge_bus.edge_idx[0] == phase_l);
   assign shift_now = !sample_now &&
      !(!phase_l && edge_bus.edge_idx == `SPMP_LAST_EDGE) &&
      !(phase_l && edge_bus.edge_idx == 4'h0);

   always_ff @(posedge I_LINK_CLK or negedge I_ARST_N) begin
      if (!I_ARST_N) begin
         start_prev <= 1'b0;
      end else begin
         start_prev <= start_s;
      end
   end

   always_ff @(posedge I_LINK_CLK or negedge I_ARST_N) begin
      if (!I_ARST_N) begin
         state <= SPMP_IDLE;
      end else begin
         case (state)
            SPMP_IDLE: begin
               if (start_evt) begin
                  state <= SPMP_RUN;
               end
            end
            SPMP_RUN: begin
               if (edge_bus.edge_stb &&
                  edge_bus.edge_idx == `SPMP_LAST_EDGE) begin
                  state <= SPMP_TAIL;
               end
            end
            SPMP_TAIL: begin
               if (tail_cnt == `SPMP_TAIL_CYC) begin
                  state <= SPMP_IDLE;
               end
            end
            default: begin
               state <= SPMP_IDLE;
            end
         endcase
      end
   end

   // Sixteen toggles per byte, parked at the polarity level
   always_ff @(posedge I_LINK_CLK or negedge I_ARST_N) begin
      if (!I_ARST_N) begin
         sck <= 1'b0;
      end else if (state != SPMP_RUN) begin
         sck <= pol_s;
      end else if (edge_bus.edge_stb) begin
         sck <= !sck;
      end
   end

   always_ff @(posedge I_LINK_CLK or negedge I_ARST_N) begin
      if (!I_ARST_N) begin
         tx_sh <= 8'h00;
         phase_l <= 1'b0;
      end else if (state == SPMP_IDLE && start_evt) begin
         tx_sh <= tx_hold;
         phase_l <= phase_hold;
      end else if (state == SPMP_RUN && edge_bus.edge_stb &&
         shift_now) begin
         tx_sh <= {tx_sh[6:0], 1'b0};
      end
   end

   // MISO is two flops late, so the capture strobe is delayed to match
   always_ff @(posedge I_LINK_CLK or negedge I_ARST_N) begin
      if (!I_ARST_N) begin
         samp_pipe <= 2'b00;
      end else begin
         samp_pipe <= {samp_pipe[0],
            edge_bus.run && edge_bus.edge_stb && sample_now};
      end
   end

   always_ff @(posedge I_LINK_CLK or negedge I_ARST_N) begin
      if (!I_ARST_N) begin
         rx_sh <= 8'h00;
      end else if (samp_pipe[1]) begin
         rx_sh <= {rx_sh[6:0], miso_s};
      end
   end

   always_ff @(posedge I_LINK_CLK or negedge I_ARST_N) begin
      if (!I_ARST_N) begin
         tail_cnt <= 2'b00;
      end else if (state == SPMP_TAIL) begin
         tail_cnt <= tail_cnt + 2'b01;
      end else begin
         tail_cnt <= 2'b00;
      end
   end

   // Received byte stays put until the next transfer ends, covering the
   // core's read after the toggle arrives
   always_ff @(posedge I_LINK_CLK or negedge I_ARST_N) begin
      if (!I_ARST_N) begin
         rx_out <= 8'h00;
         done_tgl <= 1'b0;
      end else if (state == SPMP_TAIL && tail_cnt == `SPMP_TAIL_CYC) begin
         rx_out <= rx_sh;
         done_tgl <= !done_tgl;
      end
   end
endmodule : spmp_port

/* File: spmp_port_sva.sv */
// Concurrent checks on the serial port's top-level pins
`timescale 1ns/10ps
module spmp_port_sva (
   input wire logic I_CORE_CLK,
   input wire logic I_ARST_N,
   input wire logic I_LINK_CLK,
   input wire logic I_CTRL_WE,
   input wire logic [7:0] I_CTRL_WDATA,
   input wire logic [7:0] O_CTRL,
   input wire logic [7:0] I_CONFIG,
   input wire logic [7:0] I_CLK_RATE,
   input wire logic O_BUSY,
   input wire logic I_IRQ_EN,
   input wire logic O_IRQ,
   input wire logic O_SCK,
   input wire logic O_SCK_OE,
   input wire logic O_MOSI_OE,
   input wire logic I_SS,
   input wire logic O_SS,
   input wire logic O_SS_OE
);
   // ====================
   // Helper counters
   logic [7:0] hold_cnt;
   logic [7:0] idle_cnt;

   always_ff @(posedge I_LINK_CLK or negedge I_ARST_N) begin
      if (!I_ARST_N) begin
         hold_cnt <= 8'h00;
      end else if ($changed(O_SCK)) begin
         hold_cnt <= 8'h00;
      end else if (hold_cnt != 8'hFF) begin
         hold_cnt <= hold_cnt + 8'h01;
      end
   end

   // Idle time only counts with a steady polarity setting
   always_ff @(posedge I_CORE_CLK or negedge I_ARST_N) begin
      if (!I_ARST_N) begin
         idle_cnt <= 8'h00;
      end else if (O_BUSY || $changed(I_CONFIG)) begin
         idle_cnt <= 8'h00;
      end else if (idle_cnt != 8'hFF) begin
         idle_cnt <= idle_cnt + 8'h01;
      end
   end

   // ====================
   // Assertions
   sequence s_fault_cond;
      !I_SS && O_CTRL[3:2] == 2'b01 && O_CTRL[0];
   endsequence
   sequence s_fault_set;
      O_CTRL[5] && !O_CTRL[6] && !O_CTRL[0];
   endsequence

   a_fault_clears: assert property (
      @(posedge I_CORE_CLK) disable iff (!I_ARST_N)
      s_fault_cond [*2] |-> ##[0:4] s_fault_set)
      else $error("select low did not raise a mode fault");
   a_irq_level: assert property (
      @(posedge I_CORE_CLK) disable iff (!I_ARST_N)
      O_IRQ == (I_IRQ_EN && (O_CTRL[7] || O_CTRL[5])))
      else $error("interrupt request level wrong");
   a_no_self_enable: assert property (
      @(posedge I_CORE_CLK) disable iff (!I_ARST_N)
      $rose(O_CTRL[0]) |-> $past(I_CTRL_WE) && $past(I_CTRL_WDATA[0]))
      else $error("port enabled without a write");
   a_oe_master: assert property (
      @(posedge I_CORE_CLK) disable iff (!I_ARST_N)
      $rose(O_SCK_OE) |-> O_CTRL[6] && O_CTRL[0] && O_MOSI_OE)
      else $error("pins driven outside master operation");
   a_ss_drive: assert property (
      @(posedge I_CORE_CLK) disable iff (!I_ARST_N)
      O_CTRL[3] ##1 O_CTRL[3] && $stable(O_CTRL[2])
      |-> O_SS_OE && O_SS == O_CTRL[2])
      else $error("select output does not follow mode bit");
   a_ss_input: assert property (
      @(posedge I_CORE_CLK) disable iff (!I_ARST_N)
      !O_CTRL[3] [*2] |-> !O_SS_OE)
      else $error("select pin driven while not an output");
   a_load_start: assert property (
      @(posedge I_CORE_CLK) disable iff (!I_ARST_N)
      O_CTRL[1] && !O_BUSY && O_CTRL[6] && O_CTRL[0]
      |=> O_BUSY && !O_CTRL[1])
      else $error("buffered byte did not start a transfer");
   a_busy_done: assert property (
      @(posedge I_CORE_CLK) disable iff (!I_ARST_N)
      $fell(O_BUSY) |-> O_CTRL[7])
      else $error("transfer ended without done flag");
   a_sck_idle: assert property (
      @(posedge I_CORE_CLK) disable iff (!I_ARST_N)
      idle_cnt >= 8'h28 |-> O_SCK == I_CONFIG[4])
      else $error("idle clock not at polarity level");
   a_sck_rate: assert property (
      @(posedge I_LINK_CLK) disable iff (!I_ARST_N)
      $changed(O_SCK) && O_BUSY |-> hold_cnt >= I_CLK_RATE)
      else $error("serial clock half period too short");
endmodule : spmp_port_sva

bind spmp_port spmp_port_sva chk_u (
   .I_CORE_CLK(I_CORE_CLK), .I_ARST_N(I_ARST_N),
   .I_LINK_CLK(I_LINK_CLK), .I_CTRL_WE(I_CTRL_WE),
   .I_CTRL_WDATA(I_CTRL_WDATA), .O_CTRL(O_CTRL), .I_CONFIG(I_CONFIG),
   .I_CLK_RATE(I_CLK_RATE), .O_BUSY(O_BUSY), .I_IRQ_EN(I_IRQ_EN),
   .O_IRQ(O_IRQ), .O_SCK(O_SCK), .O_SCK_OE(O_SCK_OE),
   .O_MOSI_OE(O_MOSI_OE), .I_SS(I_SS), .O_SS(O_SS), .O_SS_OE(O_SS_OE));

/* File: spmp_slave_model.sv */
// Behavioural slave at the far end of the serial link
`timescale 1ns/10ps
module spmp_slave_model (
   input wire logic i_sck,
   input wire logic i_mosi,
   input wire logic i_phase,
   input wire logic i_pol,
   input wire logic i_load,
   input wire logic [7:0] i_byte,
   output logic o_miso,
   output logic [7:0] o_rx
);
   logic [7:0] sh = 8'h00;
   int n = 0;

   initial o_rx = 8'h00;

   // Line starts released (inverted) in phase 1 until the first edge
   always @(posedge i_load) begin
      sh = i_byte;
      n = 0;
      o_miso = i_phase ? ~i_byte[7] : i_byte[7];
   end

   // Same phase and polarity as the master
   always @(i_sck) begin
      n++;
      if ((i_sck !== i_pol) && !i_phase) begin
         o_rx = {o_rx[6:0], i_mosi};
      end else if (i_sck !== i_pol) begin
         o_miso = sh[7];
      end else if (!i_phase) begin
         sh = {sh[6:0], o_rx[0]};
         o_miso = sh[7];
      end else begin
         o_rx = {o_rx[6:0], i_mosi};
         sh = {sh[6:0], i_mosi};
      end
      // Release after the hold time; loopback byte comes next
      if (n == 16) begin
         n = 0;
         o_miso <= #100 (i_phase ? ~sh[7] : sh[7]);
      end
   end
endmodule : spmp_slave_model

/* File: tb.sv */
// Testbench: master transfers, select modes and mode fault
`timescale 1ns/10ps
module tb;
   import spmp_pkg::*;
   logic clk = 1'b0;
   logic lclk = 1'b0;
   logic rst_n = 1'b0;
   logic ctl_we = 1'b0;
   logic dat_we = 1'b0;
   logic irq_en = 1'b1;
   logic ss = 1'b1;
   logic ld = 1'b0;
   logic [7:0] wd = 8'h00;
   logic [7:0] cfg = 8'h00;
   logic [7:0] rate = 8'h01;
   logic [7:0] ld_byte = 8'h00;
   logic [7:0] ctl, data, srx;
   logic busy, irq, sck, sck_oe, mosi, mosi_oe, miso, ss_o, ss_oe;
   int err_count = 0;
   int checked = 0;
   int cyc = 0;
   int edges = 0;
   realtime t_last = 0.0;
   realtime gap = 0.0;

   initial forever #4 clk = ~clk;
   initial begin
      #7;
      forever #24 lclk = ~lclk;
   end

   spmp_port dut_u (.I_CORE_CLK(clk), .I_ARST_N(rst_n), .I_LINK_CLK(lclk),
      .I_CTRL_WE(ctl_we), .I_CTRL_WDATA(wd), .O_CTRL(ctl), .I_CONFIG(cfg),
      .I_CLK_RATE(rate), .I_DATA_WE(dat_we), .I_DATA_WDATA(wd),
      .O_DATA(data), .O_BUSY(busy), .I_IRQ_EN(irq_en), .O_IRQ(irq),
      .O_SCK(sck), .O_SCK_OE(sck_oe), .O_MOSI(mosi), .O_MOSI_OE(mosi_oe),
      .I_MISO(miso), .I_SS(ss), .O_SS(ss_o), .O_SS_OE(ss_oe));

   spmp_slave_model slave_u (.i_sck(sck), .i_mosi(mosi), .i_phase(cfg[5]),
      .i_pol(cfg[4]), .i_load(ld), .i_byte(ld_byte), .o_miso(miso),
      .o_rx(srx));

   always @(sck) begin
      if (rst_n) begin
         gap = $realtime - t_last;
         t_last = $realtime;
         edges++;
      end
   end

   // ====================
   // Access tasks
   task automatic chk(input string nm, input logic [7:0] exp,
      input logic [7:0] got);
      checked++;
      if (got !== exp) begin
         err_count++;
         $display("[FAIL] %s expected %h seen %h", nm, exp, got);
      end
   endtask : chk

   task automatic wr(input logic is_dat, input logic [7:0] d);
      @(negedge clk);
      ctl_we = !is_dat;
      dat_we = is_dat;
      wd = d;
      @(negedge clk);
      ctl_we = 1'b0;
      dat_we = 1'b0;
   endtask : wr

   task automatic wait_done();
      int n;
      n = 0;
      while (ctl[7] !== 1'b1 && n < 3000) begin
         @(negedge clk);
         n++;
      end
      if (n == 3000) chk("done wait", 8'h01, 8'h00);
   endtask : wait_done

   task automatic setup(input logic [1:0] md, input logic [7:0] rt,
      input logic [7:0] ret);
      wr(1'b0, 8'h04);
      cfg = {2'b00, md, 4'h0};
      rate = rt;
      repeat (30) @(negedge clk);
      ld_byte = ret;
      ld = 1'b1;
      @(negedge clk);
      ld = 1'b0;
      wr(1'b0, 8'h45);
      chk("pin oe", 8'h03, {6'h0, sck_oe, mosi_oe});
      edges = 0;
   endtask : setup

   task automatic xfer(input logic [1:0] md, input logic [7:0] rt,
      input logic [7:0] tx, input logic [7:0] ret);
      setup(md, rt, ret);
      wr(1'b1, tx);
      wait_done();
      chk("rx byte", ret, data);
      chk("irq", 8'h01, irq);
      chk("slave rx", tx, srx);
      chk("edges", 8'h10, 8'(edges));
      chk("half period", rt + 8'h01, 8'(int'(gap) / 48));
      chk("idle sck", md[0], sck);
      wr(1'b0, 8'h45);
      chk("irq clear", 8'h00, irq);
   endtask : xfer

   task automatic test_done();
      if (err_count == 0 && checked > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask : test_done

   always @(posedge clk) begin
      cyc++;
      if (cyc == 20000) begin
         err_count++;
         test_done();
      end
   end

   // ====================
   // Main sequence
   // Port only acts as master: no outside clock drives it
   initial begin
      repeat (5) @(negedge clk);
      chk("ctl reset", 8'h04, ctl);
      chk("pins reset", 8'h01,
         {4'h0, sck_oe, mosi_oe, ss_oe, ss_o});
      chk("data reset", 8'h00, data);
      rst_n = 1'b1;
      for (int m = 0; m < 4; m++) begin
         xfer(2'(m), 8'(1 + m % 3), 8'h96 ^ 8'(m * 37),
            8'h5A + 8'(m));
      end
      // Second byte waits in the buffer behind the first
      setup(2'b00, 8'h01, 8'hA5);
      wr(1'b1, 8'h3C);
      wr(1'b1, 8'hC3);
      repeat (3) @(negedge clk);
      chk("tx full", 8'h01, ctl[1]);
      wait_done();
      chk("first rx", 8'hA5, data);
      // Done flag stays set, but a masked request must stay low
      irq_en = 1'b0;
      @(negedge clk);
      chk("irq masked", 8'h00, irq);
      irq_en = 1'b1;
      wr(1'b0, 8'h45);
      wait_done();
      chk("second rx", 8'h3C, data);
      chk("second tx", 8'hC3, srx);
      wr(1'b0, 8'h45);
      // Rival master pulls select low
      ss = 1'b0;
      repeat (5) @(negedge clk);
      chk("fault ctl", 8'h24, ctl);
      chk("fault irq", 8'h01, irq);
      repeat (20) @(negedge clk);
      chk("stays off", 8'h24, ctl);
      ss = 1'b1;
      repeat (4) @(negedge clk);
      wr(1'b0, 8'h45);
      chk("re-enable", 8'h45, ctl);
      wr(1'b0, 8'h41);
      ss = 1'b0;
      repeat (5) @(negedge clk);
      chk("3-wire ctl", 8'h41, ctl);
      chk("3-wire oe", 8'h00, ss_oe);
      wr(1'b0, 8'h49);
      chk("4-wire low", 8'h02, {6'h0, ss_oe, ss_o});
      wr(1'b0, 8'h4D);
      chk("4-wire high", 8'h03, {6'h0, ss_oe, ss_o});
      ss = 1'b1;
      repeat (4) @(negedge clk);
      wr(1'b0, 8'h45);
      chk("multi input", 8'h01, {6'h0, ss_oe, ss_o});
      test_done();
   end
endmodule : tb
